// ===== hdl/pch_pkg.sv
package pch_pkg;
    // ****************************************
    // frame layout
    // ****************************************
    localparam int FRAME_BYTES = 9;                     // address, instr, type, bank, 4 value, checksum
    localparam logic [3:0] IDX_LAST = 4'h8;             // checksum byte index
    // ****************************************
    // instruction numbers
    // ****************************************
    localparam logic [7:0] INS_AXIS_READ = 8'h06;
    localparam logic [7:0] INS_GLOBAL_WRITE = 8'h09;
    localparam logic [7:0] INS_GLOBAL_READ = 8'h0a;
    localparam logic [7:0] INS_GLOBAL_STORE = 8'h0b;
    localparam logic [7:0] INS_GLOBAL_RESTORE = 8'h0c;
    // ****************************************
    // banks, parameters, status codes
    // ****************************************
    localparam logic [7:0] BANK_MODULE = 8'h00;
    localparam logic [7:0] BANK_USER = 8'h02;
    localparam logic [7:0] BANK_IRQ = 8'h03;
    localparam logic [7:0] AXIS_MAX = 8'h05;
    localparam logic [7:0] AP_ACTUAL_POS = 8'h01;
    localparam logic [7:0] GP_SERIAL_ADDR = 8'h42;
    localparam logic [7:0] ST_OK = 8'h64;               // 100
    localparam logic [7:0] ST_BAD_CHECKSUM = 8'h01;
    localparam logic [7:0] ST_BAD_COMMAND = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE = 8'h03;
    localparam logic [7:0] ST_BAD_VALUE = 8'h04;
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] SERIAL_ADDR_RST = 8'h01;
    localparam logic [31:0] ACC_RST = 32'h0000_0000;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] instr;
        logic [31:0] value;
    } pch_reply_t;
    typedef struct packed {
        logic req;                                      // one-cycle write request
        logic [7:0] index;                              // parameter number
        logic [31:0] data;
    } pch_nvm_wr_t;
    typedef enum logic [1:0] {PCH_IDLE, PCH_LOAD, PCH_EXEC, PCH_WAIT} pch_state_t;
endpackage

// ===== hdl/pch_handler.sv
`timescale 1ns/1ps
// How it works
// - frame: addr, instr, type, bank, value, sum
// - instruction 6 reads axis parameter, into accumulator in standalone mode
// - axis read reply: status 100 with value
// - on axis reads direct mode keeps accumulator; standalone loads it
// - axis type 1 returns actual position
// - instruction 9 writes global in banks 0/2/3
// - bank0 module, bank2 user, bank3 interrupt config
// - bank 0 writes commit to non-volatile memory
// - global write acknowledged with status 100
// - parameter 66 bank 0 is serial address
// - instruction 10 reads global, replies status 100
// - every bank 0/2/3 global is readable
// - instruction 11 bank 2 stores user variable
// - user variables restored from memory after power-up
// - restore overwrites changed user variable
// - instruction 12 bank 2 restores, status 100
module pch_handler
(
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_valid,                          // one byte of a frame
    input wire logic [7:0] rx_byte,
    input wire logic standalone_mode,                   // high: axis reads also load accumulator
    input wire logic [31:0] actual_pos [6],             // per-axis actual position
    input wire logic [31:0] axis_param_data,            // other axis parameters, outside table
    input wire logic [31:0] nvm_user_rd [256],          // non-volatile user variable image
    input wire logic [31:0] nvm_module_rd [256],        // non-volatile module setting image
    input wire logic boot_done,                         // non-volatile image valid after power-up
    output pch_pkg::pch_reply_t reply,
    output logic reply_valid,
    output logic [7:0] axis_param_sel,                  // type byte for outside axis table
    output logic [2:0] axis_sel,
    output pch_pkg::pch_nvm_wr_t nvm_user_wr,
    output pch_pkg::pch_nvm_wr_t nvm_module_wr,
    output logic [31:0] acc,
    output logic [7:0] serial_addr
);
    import pch_pkg::*;

    // ****************************************
    // frame assembly
    // ****************************************
    logic [7:0] frame_q [FRAME_BYTES];                  // received bytes by index
    logic [3:0] idx_q;                                  // next byte position
    logic [7:0] sum_q;                                  // running checksum
    logic go_q;                                         // frame complete this cycle
    logic sum_ok_q;
    logic [31:0] user_q [256];                          // bank 2 user variables
    logic [31:0] module_q [256];                        // bank 0 module settings
    logic [31:0] irq_q [256];                           // bank 3 interrupt configuration
    logic restored_q;                                   // power-up restore done
    logic [7:0] serial_addr_q;                          // live serial address
    pch_reply_t reply_q;                                // last answer, held until the next one
    logic reply_valid_q;                                // one-cycle answer strobe
    logic [31:0] acc_q;                                 // accumulator seen by standalone programs
    pch_nvm_wr_t user_wr_q, module_wr_q;                // write requests towards the memory

    // the checksum byte is the ninth; there is no frame timeout, so a lost
    // byte shifts the framing until the next reset
    wire last_byte = rx_valid && (idx_q == IDX_LAST);

    // collect bytes in arrival order, msb of value first
    // frame_q has no reset: before a whole frame is in it reaches only axis_sel, axis_param_sel and the unqualified memory write index and data
    always_ff @(posedge clk) begin
        if (rst) begin
            idx_q <= 4'h0;
            sum_q <= 8'h00;
        end else if (rx_valid) begin
            frame_q[idx_q] <= rx_byte;
            idx_q <= last_byte ? 4'h0 : idx_q + 4'h1;
            sum_q <= last_byte ? 8'h00 : sum_q + rx_byte;
        end
    end

    // checksum verdict is latched with the frame strobe
    // a bad sum is still answered, so the host is never left waiting
    always_ff @(posedge clk) begin
        if (rst) begin
            go_q <= 1'b0;
            sum_ok_q <= 1'b0;
        end else begin
            go_q <= last_byte;
            sum_ok_q <= last_byte && (rx_byte == sum_q);
        end
    end

    // ****************************************
    // decode
    // ****************************************
    // fields stay put from the checksum byte until byte 1 of the next frame,
    // so decoding one cycle later is safe even for back-to-back frames
    wire [7:0] f_ins = frame_q[1];                      // instruction number
    wire [7:0] f_type = frame_q[2];                     // parameter number
    wire [7:0] f_bank = frame_q[3];                     // axis or bank
    wire [31:0] f_val = {frame_q[4], frame_q[5], frame_q[6], frame_q[7]};
    wire axis_ok = f_bank <= AXIS_MAX;
    wire bank_ok = (f_bank == BANK_MODULE) || (f_bank == BANK_USER) || (f_bank == BANK_IRQ);
    wire is_axis_rd = f_ins == INS_AXIS_READ;
    wire is_gwr = f_ins == INS_GLOBAL_WRITE;
    wire is_grd = f_ins == INS_GLOBAL_READ;
    wire is_store = f_ins == INS_GLOBAL_STORE;
    wire is_rest = f_ins == INS_GLOBAL_RESTORE;
    // a frame is carried out only when sum, instruction and bank all pass
    wire known = is_axis_rd || is_gwr || is_grd || is_store || is_rest;
    wire bank_good = is_axis_rd ? axis_ok : ((is_store || is_rest) ? (f_bank == BANK_USER) : bank_ok);
    wire do_cmd = go_q && sum_ok_q && known && bank_good;
    // axis read: type 1 is actual position, the rest comes from outside
    wire [31:0] axis_val = (f_type == AP_ACTUAL_POS) ? actual_pos[f_bank[2:0]] : axis_param_data;
    // global read per bank; serial address lives in its own flop
    wire [31:0] mod_val = (f_type == GP_SERIAL_ADDR) ? {24'h000000, serial_addr_q} : module_q[f_type];
    wire [31:0] glob_val = (f_bank == BANK_USER) ? user_q[f_type] :
                           (f_bank == BANK_IRQ) ? irq_q[f_type] : mod_val;
    wire [31:0] rd_val = is_axis_rd ? axis_val : glob_val;
    // only reads return data; writes, stores and restores answer with zero
    wire rd_cmd = is_axis_rd || is_grd;
    // a bad sum outranks an unknown instruction, which outranks a bad bank
    wire [7:0] err_st = !sum_ok_q ? ST_BAD_CHECKSUM : (!known ? ST_BAD_COMMAND : ST_BAD_VALUE);
    wire do_gwr = do_cmd && is_gwr;
    wire do_rest = do_cmd && is_rest;

    // ****************************************
    // parameter stores
    // ****************************************
    // one process per entry; restore at power-up and on command shares the path
    // the boot image wins over a command in the same cycle: no frame is decoded
    // before boot_done in a running system, and the image must not be half applied
    // bank 3 has no image, so interrupt setup starts from zero after every reset
    genvar gi;
    generate
        for (gi = 0; gi < 256; gi++) begin : g_store
            always_ff @(posedge clk) begin
                if (rst) begin
                    user_q[gi] <= 32'h0000_0000;
                    module_q[gi] <= 32'h0000_0000;
                    irq_q[gi] <= 32'h0000_0000;
                end else if (!restored_q && boot_done) begin
                    user_q[gi] <= nvm_user_rd[gi];
                    module_q[gi] <= nvm_module_rd[gi];
                end else if (do_gwr && f_type == 8'(gi)) begin
                    if (f_bank == BANK_USER) user_q[gi] <= f_val;
                    else if (f_bank == BANK_IRQ) irq_q[gi] <= f_val;
                    else module_q[gi] <= f_val;
                end else if (do_rest && f_type == 8'(gi)) begin
                    user_q[gi] <= nvm_user_rd[gi];
                end
            end
        end
    endgenerate

    // serial address follows its bank 0 slot and the boot image
    // it has its own flop so that a usable address exists before the image
    // is valid; only the low byte of the written value is kept
    // restored_q makes the boot load happen once per reset, never again later
    always_ff @(posedge clk) begin
        if (rst) begin
            serial_addr_q <= SERIAL_ADDR_RST;
            restored_q <= 1'b0;
        end else begin
            if (!restored_q && boot_done) begin
                restored_q <= 1'b1;
                serial_addr_q <= nvm_module_rd[GP_SERIAL_ADDR][7:0];
            end else if (do_gwr && f_bank == BANK_MODULE && f_type == GP_SERIAL_ADDR) begin
                serial_addr_q <= f_val[7:0];
            end
        end
    end

    // ****************************************
    // non-volatile write requests
    // ****************************************
    // bank 0 writes go out automatically; bank 2 only on explicit store
    // index and data refresh every cycle; only req qualifies them
    // a store sends the variable as it stood before this cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            user_wr_q <= '0;
            module_wr_q <= '0;
        end else begin
            module_wr_q.req <= do_gwr && f_bank == BANK_MODULE;
            module_wr_q.index <= f_type;
            module_wr_q.data <= f_val;
            user_wr_q.req <= do_cmd && is_store;
            user_wr_q.index <= f_type;
            user_wr_q.data <= user_q[f_type];
        end
    end

    // ****************************************
    // reply and accumulator
    // ****************************************
    // every frame gets one reply; writes carry zero as the don't-care value
    // reply fields only change on a frame, so the host may read them late
    // standalone mode matters for axis reads only; global reads always load acc
    always_ff @(posedge clk) begin
        if (rst) begin
            reply_q <= '0;
            reply_valid_q <= 1'b0;
            acc_q <= ACC_RST;
        end else begin
            reply_valid_q <= go_q;
            if (go_q) begin
                reply_q.instr <= f_ins;
                reply_q.status <= do_cmd ? ST_OK : err_st;
                reply_q.value <= (do_cmd && rd_cmd) ? rd_val : 32'h0000_0000;
            end
            if (do_cmd && ((is_axis_rd && standalone_mode) || is_grd)) begin
                acc_q <= rd_val;
            end
        end
    end

    // outputs are the flops themselves, with no logic after them
    assign serial_addr = serial_addr_q;
    assign reply = reply_q;
    assign reply_valid = reply_valid_q;
    assign acc = acc_q;
    assign nvm_user_wr = user_wr_q;
    assign nvm_module_wr = module_wr_q;
    // axis selection is a pure decode of stored frame bytes, held in flops
    assign axis_param_sel = frame_q[2];
    assign axis_sel = frame_q[3][2:0];
endmodule

// ===== sim/pch_handler_asserts.sv
`timescale 1ns/1ps
// ****************************************
// frame tracking and reply checks
// ****************************************
module pch_handler_asserts
(
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic standalone_mode,
    input wire pch_pkg::pch_reply_t reply,
    input wire logic reply_valid,
    input wire pch_pkg::pch_nvm_wr_t nvm_user_wr,
    input wire pch_pkg::pch_nvm_wr_t nvm_module_wr,
    input wire logic [31:0] acc,
    input wire logic [7:0] serial_addr
);
    import pch_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0] cnt_q; // byte position inside the frame
    logic [7:0] sum_q, ins_q, typ_q, bank_q;
    logic [31:0] val_q;
    wire fe = rx_valid && cnt_q == 4'h8; // checksum byte taken
    wire good = fe && sum_q == rx_byte;
    wire gw = good && ins_q == INS_GLOBAL_WRITE;
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
        end else if (rx_valid) begin
            cnt_q <= fe ? 4'h0 : cnt_q + 4'h1;
            sum_q <= fe ? 8'h00 : sum_q + rx_byte;
        end
    end
    // field capture needs no reset: only read once a whole frame is in
    always_ff @(posedge clk) begin
        if (rx_valid && cnt_q == 4'h1) ins_q <= rx_byte;
        if (rx_valid && cnt_q == 4'h2) typ_q <= rx_byte;
        if (rx_valid && cnt_q == 4'h3) bank_q <= rx_byte;
        if (rx_valid && cnt_q[3:2] == 2'h1) val_q <= {val_q[23:0], rx_byte};
    end
    sequence s_ok;
        ##2 reply_valid && reply.status == ST_OK;
    endsequence
    frame_answer_a: assert property (fe |-> ##2 reply_valid) else $error("no reply after frame");
    reply_cause_a: assert property (reply_valid |-> $past(fe, 2)) else $error("stray reply");
    bad_sum_a: assert property (fe && !good |-> ##2 reply.status == ST_BAD_CHECKSUM) else $error("sum");
    gwrite_ok_a: assert property (gw && bank_q != 8'h01 && bank_q <= BANK_IRQ |-> s_ok)
        else $error("global write not acknowledged");
    bank0_commit_a: assert property (gw && bank_q == BANK_MODULE |->
        ##2 nvm_module_wr.req && nvm_module_wr.data == val_q && nvm_module_wr.index == typ_q) else $error("no commit");
    addr_write_a: assert property (gw && bank_q == BANK_MODULE && typ_q == GP_SERIAL_ADDR |->
        ##2 serial_addr == val_q[7:0]) else $error("serial address not updated");
    user_store_a: assert property (good && ins_q == INS_GLOBAL_STORE && bank_q == BANK_USER |->
        s_ok ##0 nvm_user_wr.req && nvm_user_wr.index == typ_q) else $error("store missing");
    store_cause_a: assert property (nvm_user_wr.req |-> $past(good, 2)) else $error("stray store");
    direct_acc_a: assert property (good && ins_q == INS_AXIS_READ && !standalone_mode |->
        ##2 acc == $past(acc, 2)) else $error("accumulator changed in direct mode");
    restore_ok_a: assert property (good && ins_q == INS_GLOBAL_RESTORE && bank_q == BANK_USER |-> s_ok)
        else $error("restore not acknowledged");
endmodule
bind pch_handler pch_handler_asserts chk_u (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .standalone_mode(standalone_mode), .reply(reply), .reply_valid(reply_valid), .nvm_user_wr(nvm_user_wr),
    .nvm_module_wr(nvm_module_wr), .acc(acc), .serial_addr(serial_addr));

// ===== sim/pch_host.sv
`timescale 1ns/1ps
// ****************************************
// host side: sends command frames
// ****************************************
module pch_host (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // skew spoils the checksum on purpose when non-zero
    task automatic send(input logic [7:0] ins, typ, bnk, input logic [31:0] val, input logic [7:0] skew);
        logic [7:0] b [9];
        b = '{8'h01, ins, typ, bnk, val[31:24], val[23:16], val[15:8], val[7:0], skew};
        for (int i = 0; i < 8; i++) b[8] += b[i];
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_byte <= b[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte <= ~b[8]; // an idle line must not look like the last byte
    endtask
endmodule

// ===== sim/test_pch_handler.sv
`timescale 1ns/1ps
module test_pch_handler;
    import pch_pkg::*;
    logic clk, rst, standalone_mode, boot_done, rx_valid, reply_valid;
    logic [7:0] rx_byte, axis_param_sel, serial_addr;
    logic [2:0] axis_sel;
    logic [31:0] actual_pos [6];
    logic [31:0] axis_param_data, acc;
    logic [31:0] nvm_user_rd [256];
    logic [31:0] nvm_module_rd [256];
    pch_reply_t reply;
    pch_nvm_wr_t nvm_user_wr, nvm_module_wr, uw, mw; // uw/mw: strobes seen with the reply
    int bad_count, checks_done;
    pch_handler dut_u (.clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .standalone_mode(standalone_mode), .actual_pos(actual_pos), .axis_param_data(axis_param_data),
        .nvm_user_rd(nvm_user_rd), .nvm_module_rd(nvm_module_rd), .boot_done(boot_done), .reply(reply),
        .reply_valid(reply_valid), .axis_param_sel(axis_param_sel), .axis_sel(axis_sel),
        .nvm_user_wr(nvm_user_wr), .nvm_module_wr(nvm_module_wr), .acc(acc), .serial_addr(serial_addr));
    pch_host host_u (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte));
    task automatic chk(input logic [31:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("mismatches=%0d checks=%0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    // one frame, then a bounded wait for the reply pulse and a status check
    task automatic cmd(input logic [7:0] ins, typ, bnk, input logic [31:0] val, input logic [7:0] skew, st);
        int n;
        host_u.send(ins, typ, bnk, val, skew);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (reply_valid !== 1'b1 && n < 8);
        uw = nvm_user_wr;
        mw = nvm_module_wr;
        chk({31'h0, reply_valid}, 32'h1);
        if (reply_valid !== 1'b1) close_out();
        chk({24'h0, reply.status}, {24'h0, st});
        chk({24'h0, reply.instr}, {24'h0, ins});
    endtask
    task automatic t_global;
        logic [7:0] bk [3];
        bk = '{BANK_MODULE, BANK_USER, BANK_IRQ};
        foreach (bk[i]) begin
            cmd(INS_GLOBAL_WRITE, 8'h07, bk[i], {24'hc0de00, bk[i]}, 8'h00, ST_OK);
            chk({31'h0, mw.req}, {31'h0, bk[i] == BANK_MODULE});
            cmd(INS_GLOBAL_READ, 8'h07, bk[i], 32'h0, 8'h00, ST_OK);
            chk(reply.value, {24'hc0de00, bk[i]});
            chk(acc, {24'hc0de00, bk[i]});
        end
        // the boot image supplied the serial address before any write to it
        chk({24'h0, serial_addr}, {24'h0, nvm_module_rd[GP_SERIAL_ADDR][7:0]});
        cmd(INS_GLOBAL_WRITE, 8'h07, 8'h01, 32'h0, 8'h00, ST_BAD_VALUE);
        cmd(INS_GLOBAL_WRITE, GP_SERIAL_ADDR, BANK_MODULE, 32'h3, 8'h00, ST_OK);
        chk({24'h0, serial_addr}, 32'h3);
        cmd(INS_GLOBAL_READ, GP_SERIAL_ADDR, BANK_MODULE, 32'h0, 8'h00, ST_OK);
        chk(reply.value, 32'h3);
    endtask
    task automatic t_axis;
        cmd(INS_AXIS_READ, AP_ACTUAL_POS, AXIS_MAX, 32'h0, 8'h00, ST_OK);
        chk(reply.value, actual_pos[5]);
        chk(acc, 32'h3);
        // mode changes on a rising edge, between frames
        @(posedge clk);
        standalone_mode <= 1'b1;
        cmd(INS_AXIS_READ, 8'h07, 8'h02, 32'h0, 8'h00, ST_OK);
        chk(reply.value, axis_param_data);
        chk(acc, axis_param_data);
        chk({21'h0, axis_sel, axis_param_sel}, {21'h0, 3'h2, 8'h07});
        cmd(INS_AXIS_READ, AP_ACTUAL_POS, 8'h06, 32'h0, 8'h00, ST_BAD_VALUE);
        @(posedge clk);
        standalone_mode <= 1'b0;
    endtask
    task automatic t_nvm;
        cmd(INS_GLOBAL_READ, 8'h2a, BANK_USER, 32'h0, 8'h00, ST_OK);
        chk(reply.value, nvm_user_rd[42]);
        cmd(INS_GLOBAL_WRITE, 8'h2a, BANK_USER, 32'h1234_5678, 8'h00, ST_OK);
        cmd(INS_GLOBAL_RESTORE, 8'h2a, BANK_USER, 32'h0, 8'h00, ST_OK);
        cmd(INS_GLOBAL_READ, 8'h2a, BANK_USER, 32'h0, 8'h00, ST_OK);
        chk(reply.value, nvm_user_rd[42]);
        cmd(INS_GLOBAL_WRITE, 8'h2a, BANK_USER, 32'h9abc_def0, 8'h00, ST_OK);
        cmd(INS_GLOBAL_STORE, 8'h2a, BANK_USER, 32'h0, 8'h00, ST_OK);
        chk({uw.req, 23'h0, uw.index}, {1'b1, 23'h0, 8'h2a});
        chk(uw.data, 32'h9abc_def0);
        cmd(INS_GLOBAL_WRITE, 8'h07, BANK_MODULE, 32'h0, 8'h01, ST_BAD_CHECKSUM);
        cmd(8'h05, 8'h07, BANK_MODULE, 32'h0, 8'h00, ST_BAD_COMMAND);
    endtask
    // mid-run reset: outputs fall back, then the boot image is loaded again
    task automatic t_reset;
        @(posedge clk);
        rst <= 1'b1;
        boot_done <= 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(acc, ACC_RST);
        chk({23'h0, reply_valid, serial_addr}, {23'h0, 1'b0, SERIAL_ADDR_RST});
        @(posedge clk);
        boot_done <= 1'b1;
        cmd(INS_GLOBAL_READ, 8'h2a, BANK_USER, 32'h0, 8'h00, ST_OK);
        chk(reply.value, nvm_user_rd[42]);
        chk({24'h0, serial_addr}, {24'h0, nvm_module_rd[GP_SERIAL_ADDR][7:0]});
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst, standalone_mode, boot_done, bad_count, checks_done} = {3'b100, 64'h0};
        axis_param_data = 32'h0bad_cafe;
        foreach (actual_pos[i]) actual_pos[i] = 32'h1000_0000 + i;
        foreach (nvm_user_rd[i]) nvm_user_rd[i] = 32'h5500_0000 + i;
        foreach (nvm_module_rd[i]) nvm_module_rd[i] = 32'h6600_0000 + i;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        boot_done <= 1'b1;
        t_global();
        t_axis();
        t_nvm();
        t_reset();
        close_out();
    end
endmodule
